// ---- rtl/sprq_agent.sv ----
// agent end: accepts processor requests and returns one-word read responses
// assumes the processor end keeps its handshake; data from a user port
module sprq_agent (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_N_IN,
    // link
    sprq_link_if.agt         LINK,
    // user side
    input  wire logic        ACCEPT_EN_IN,
    input  wire logic [31:0] RESP_DATA_IN,
    input  wire logic        RESP_ERR_IN,
    output logic [4:0]       SEEN_CMD_OUT,
    output logic [31:0]      SEEN_AD_OUT,
    output logic             SEEN_VALID_OUT
);
    typedef enum logic [2:0] {
        AG_IDLE = 3'b001,
        AG_WAIT = 3'b010,
        AG_RESP = 3'b100
    } sprq_agt_st_t;
    sprq_agt_st_t st_r;
    logic         owns_n_r;
    logic         proc_valid_n_r;
    logic [4:0]   cmd_r;
    logic [1:0]   hold_r;
    always_ff @(posedge REF_CLK_IN) begin
        owns_n_r <= LINK.proc_owns_bus_n;
        proc_valid_n_r <= ~LINK.proc_valid_n;
        cmd_r    <= LINK.cmd_id_bus;
        SEEN_CMD_OUT   <= LINK.cmd_id_bus;
        SEEN_AD_OUT    <= LINK.addr_data_bus;
        SEEN_VALID_OUT <= ~LINK.proc_valid_n;
    end
    // accept held two cycles at least once raised
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            LINK.agent_accept_n <= 1'b1;
            hold_r              <= '0;
        end else if (hold_r != 2'd0) begin
            hold_r <= hold_r - 2'd1;
        end else if (ACCEPT_EN_IN && proc_valid_n_r && !cmd_r[sprq_pkg::DATA_BIT]) begin
            LINK.agent_accept_n <= 1'b0;
            hold_r              <= 2'(sprq_pkg::ACCEPT_HOLD - 1);
        end else begin
            LINK.agent_accept_n <= 1'b1;
        end
    end
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            st_r                     <= AG_IDLE;
            LINK.agt_cmd             <= '0;
            LINK.agt_ad              <= '0;
            LINK.agt_oe_n            <= 1'b1;
            LINK.agent_valid_n       <= 1'b1;
            LINK.agent_bus_request_n <= 1'b1;
        end else begin
            case (st_r)
                AG_IDLE: begin
                    if (proc_valid_n_r && !cmd_r[sprq_pkg::DATA_BIT] && cmd_r[3:0] == sprq_pkg::CMD_READ) begin
                        st_r <= AG_WAIT;
                    end
                end
                AG_WAIT: begin
                    // drive only once release has been seen a cycle earlier
                    if (owns_n_r) begin
                        LINK.agt_oe_n      <= 1'b0;
                        LINK.agent_valid_n <= 1'b0;
                        LINK.agt_ad        <= RESP_DATA_IN;
                        LINK.agt_cmd       <= {1'b1, RESP_ERR_IN ? sprq_pkg::ERR_DATA_TAG
                                                                 : sprq_pkg::END_DATA_TAG};
                        st_r               <= AG_RESP;
                    end
                end
                AG_RESP: begin
                    LINK.agt_oe_n      <= 1'b1;
                    LINK.agent_valid_n <= 1'b1;
                    st_r               <= AG_IDLE;
                end
                default: st_r <= AG_IDLE;
            endcase
        end
    end
endmodule

// ---- rtl/sprq_dev.sv ----
// processor end: issues reads and writes, hands the bus over after reads
// assumes the agent keeps its side of the handshake; write data waits in a fifo
module sprq_dev #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_N_IN,
    // link
    sprq_link_if.dev         LINK,
    // request port: len 0 = read, 1..n = write bytes
    input  wire logic        REQ_VALID_IN,
    output logic             REQ_READY_OUT,
    input  wire logic [31:0] REQ_ADDR_IN,
    input  wire logic [3:0]  REQ_LEN_IN,
    input  wire logic        RATE_SPACED_IN,
    // write data stream, one 32-bit word per data cycle
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WDATA_VALID_IN,
    output logic             WDATA_READY_OUT,
    // read response
    output logic [31:0]      RDATA_OUT,
    output logic             RDATA_VALID_OUT,
    output logic             RDATA_LAST_OUT,
    output logic             BUS_ERROR_OUT
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_SLAVE = 5'b01000,
        ST_GAP   = 5'b10000
    } sprq_dev_st_t;
    sprq_dev_st_t st_r;
    logic [4:0]   cmd_in_r;
    logic [31:0]  ad_in_r;
    logic         agent_valid_n_r;
    logic         accept_r;
    logic         accept_seen_r;
    logic         agent_bus_request_n_r;
    logic [3:0]   rem_r;
    logic         is_read_r;
    logic         spaced_r;
    logic [1:0]   wait_r;
    logic [1:0]   gap_r;
    logic [3:0]   split_r;
    logic [31:0]  split_addr_r;
    logic         read_pend_r;
    logic         fifo_valid;
    logic [31:0]  fifo_data;
    logic         fifo_pop;
    logic         resp_end;
    // input capture on the clock edge
    always_ff @(posedge REF_CLK_IN) begin
        cmd_in_r <= LINK.cmd_id_bus;
        ad_in_r  <= LINK.addr_data_bus;
        agent_valid_n_r <= ~LINK.agent_valid_n;
        accept_r <= ~LINK.agent_accept_n;
        agent_bus_request_n_r   <= ~LINK.agent_bus_request_n;
    end
    sprq_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .clk_in       (REF_CLK_IN),
        .rst_n_in     (RST_N_IN),
        .in_data_in   (WDATA_IN),
        .in_valid_in  (WDATA_VALID_IN),
        .in_ready_out (WDATA_READY_OUT),
        .out_data_out (fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in (fifo_pop)
    );
    // fifo drains only on a paced data cycle; an empty fifo stalls the write
    assign fifo_pop = (st_r == ST_DATA) && (wait_r == 2'd0) && fifo_valid;
    assign resp_end = (st_r == ST_SLAVE) && agent_valid_n_r && cmd_in_r[sprq_pkg::DATA_BIT]
                      && (cmd_in_r[3:0] != sprq_pkg::MORE_DATA_TAG);
    // ready stays combinational so a waiting request is taken on the first edge after the device returns to idle
    // with no split half left; registering it would cost a cycle between dense writes
    assign REQ_READY_OUT = (st_r == ST_IDLE) && (split_r == sprq_pkg::LEN_RESET)
                           && !read_pend_r;
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            st_r              <= ST_IDLE;
            LINK.dev_cmd      <= '0;
            LINK.dev_ad       <= '0;
            LINK.dev_oe_n     <= 1'b0;
            LINK.proc_valid_n <= 1'b1;
            LINK.proc_owns_bus_n <= 1'b0;
            rem_r         <= '0;
            is_read_r     <= 1'b0;
            spaced_r      <= 1'b0;
            wait_r        <= '0;
            gap_r         <= '0;
            split_r       <= sprq_pkg::LEN_RESET;
            split_addr_r  <= '0;
            read_pend_r   <= 1'b0;
            accept_seen_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    LINK.proc_valid_n <= 1'b1;
                    accept_seen_r     <= 1'b0;
                    if (split_r != sprq_pkg::LEN_RESET) begin
                        // second half of a 5..7 byte write
                        LINK.dev_cmd      <= {1'b0, sprq_pkg::CMD_WRITE};
                        LINK.dev_ad       <= split_addr_r;
                        LINK.proc_valid_n <= 1'b0;
                        rem_r             <= 4'd1;
                        is_read_r         <= 1'b0;
                        split_r           <= sprq_pkg::LEN_RESET;
                        st_r              <= ST_ADDR;
                    end else if (REQ_VALID_IN && !read_pend_r) begin
                        is_read_r         <= (REQ_LEN_IN == 4'd0);
                        spaced_r          <= RATE_SPACED_IN;
                        LINK.dev_cmd      <= {1'b0, (REQ_LEN_IN == 4'd0) ? sprq_pkg::CMD_READ
                                                                         : sprq_pkg::CMD_WRITE};
                        LINK.dev_ad       <= REQ_ADDR_IN;
                        LINK.proc_valid_n <= 1'b0;
                        if (REQ_LEN_IN > 4'd4 && REQ_LEN_IN < 4'd8) begin
                            rem_r        <= 4'd1;
                            split_r      <= REQ_LEN_IN - 4'd4;
                            split_addr_r <= REQ_ADDR_IN + 32'h4;
                        end else begin
                            rem_r <= (REQ_LEN_IN <= 4'd4) ? 4'd1 : REQ_LEN_IN >> 2;
                        end
                        st_r <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // address cycle repeats until accept seen, then one more cycle
                    if (accept_r) begin
                        accept_seen_r <= 1'b1;
                    end
                    if (accept_r && accept_seen_r) begin
                        if (is_read_r) begin
                            LINK.proc_owns_bus_n <= 1'b1;
                            LINK.dev_oe_n        <= 1'b1;
                            LINK.proc_valid_n    <= 1'b1;
                            read_pend_r          <= 1'b1;
                            st_r                 <= ST_SLAVE;
                        end else begin
                            LINK.proc_valid_n <= 1'b1;
                            wait_r            <= 2'd0;
                            st_r              <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    LINK.proc_valid_n <= 1'b1;
                    if (wait_r != 2'd0) begin
                        wait_r <= wait_r - 2'd1;
                    end else if (fifo_valid) begin
                        LINK.dev_cmd      <= {1'b1, (rem_r == 4'd1) ? sprq_pkg::END_DATA_TAG
                                                                    : sprq_pkg::MORE_DATA_TAG};
                        LINK.dev_ad       <= fifo_data;
                        LINK.proc_valid_n <= 1'b0;
                        rem_r             <= rem_r - 4'd1;
                        wait_r            <= spaced_r ? 2'(sprq_pkg::SPACED_WAITS) : 2'd0;
                        if (rem_r == 4'd1) begin
                            // spaced pattern leaves two idle cycles before next request
                            gap_r <= spaced_r ? 2'(sprq_pkg::SPACED_WAITS) : 2'd0;
                            st_r  <= spaced_r ? ST_GAP : ST_IDLE;
                        end
                    end
                end
                // idle cycles after the last spaced data word, before the next request
                ST_GAP: begin
                    LINK.proc_valid_n <= 1'b1;
                    gap_r <= gap_r - 2'd1;
                    if (gap_r == 2'd1) begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_SLAVE: begin
                    // the input register already costs one cycle, so taking the bus back on the
                    // edge that sees the last data lands two cycles after that data cycle
                    if (resp_end) begin
                        read_pend_r <= 1'b0;
                        if (!agent_bus_request_n_r) begin
                            LINK.proc_owns_bus_n <= 1'b0;
                            LINK.dev_oe_n        <= 1'b0;
                            st_r                 <= ST_IDLE;
                        end
                    end else if (!read_pend_r && !agent_bus_request_n_r) begin
                        // agent kept the bus after the response; take it back once it lets go
                        LINK.proc_owns_bus_n <= 1'b0;
                        LINK.dev_oe_n        <= 1'b0;
                        st_r                 <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    // read response outputs pulse for one cycle per data word, error included
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT       <= '0;
            RDATA_VALID_OUT <= 1'b0;
            RDATA_LAST_OUT  <= 1'b0;
            BUS_ERROR_OUT   <= 1'b0;
        end else begin
            RDATA_VALID_OUT <= (st_r == ST_SLAVE) && agent_valid_n_r && cmd_in_r[sprq_pkg::DATA_BIT];
            RDATA_LAST_OUT  <= resp_end;
            RDATA_OUT       <= ad_in_r;
            BUS_ERROR_OUT   <= (st_r == ST_SLAVE) && agent_valid_n_r && cmd_in_r[sprq_pkg::DATA_BIT]
                               && (cmd_in_r[3:0] == sprq_pkg::ERR_DATA_TAG);
        end
    end
endmodule

// ---- rtl/sprq_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-low reset
module sprq_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;
    assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rd_r];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- rtl/sprq_link_if.sv ----
// wires between processor end and agent end
// assumes the bench resolves buses from the two output enables (low = driving)
interface sprq_link_if;
    logic [4:0]  dev_cmd;
    logic [31:0] dev_ad;
    logic        dev_oe_n;
    logic [4:0]  agt_cmd;
    logic [31:0] agt_ad;
    logic        agt_oe_n;
    logic [4:0]  cmd_id_bus;
    logic [31:0] addr_data_bus;
    logic        proc_valid_n;
    logic        agent_valid_n;
    logic        agent_accept_n;
    logic        proc_owns_bus_n;
    logic        agent_bus_request_n;
    modport dev (output dev_cmd, dev_ad, dev_oe_n, proc_valid_n, proc_owns_bus_n,
                 input cmd_id_bus, addr_data_bus, agent_valid_n, agent_accept_n, agent_bus_request_n);
    modport agt (output agt_cmd, agt_ad, agt_oe_n, agent_valid_n, agent_accept_n, agent_bus_request_n,
                 input cmd_id_bus, addr_data_bus, proc_valid_n, proc_owns_bus_n);
endinterface

// ---- rtl/sprq_pkg.sv ----
// shared constants for the processor request link (device end and agent end)
// assumes one 100 mhz clock shared by both ends and a bench that resolves the wires
package sprq_pkg;
    localparam int          CMD_W         = 5;
    localparam int          AD_W          = 32;
    localparam logic [3:0]  CMD_READ      = 4'h1;
    localparam logic [3:0]  CMD_WRITE     = 4'h2;
    localparam logic [3:0]  MORE_DATA_TAG = 4'h0;
    localparam logic [3:0]  END_DATA_TAG  = 4'h1;
    localparam logic [3:0]  ERR_DATA_TAG  = 4'h2;
    localparam int          DATA_BIT      = 4;
    localparam int          ACCEPT_HOLD   = 2;
    localparam int          SPACED_WAITS  = 2;
    localparam int          RECLAIM_DELAY = 2;
    localparam logic [3:0]  LEN_RESET     = 4'h0;
endpackage

// ---- verification/sprq_link_properties.sv ----
// assertions on the processor request link, watching the interface wires only
// assumes one clock and the synchronous active-low reset shared by both ends
module sprq_link_properties (
    // clock and reset
    input wire logic       REF_CLK_IN,
    input wire logic       RST_N_IN,
    // link
    input wire logic [4:0] dev_cmd,
    input wire logic       dev_oe_n,
    input wire logic [4:0] agt_cmd,
    input wire logic       agt_oe_n,
    input wire logic       proc_valid_n,
    input wire logic       agent_valid_n,
    input wire logic       agent_accept_n,
    input wire logic       proc_owns_bus_n,
    input wire logic       agent_bus_request_n
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic rd_prev_r;
    logic read_pending_r;
    wire  addr_cyc = !proc_valid_n && !dev_oe_n && !dev_cmd[4];
    wire  rd_cyc   = addr_cyc && dev_cmd[3:0] == sprq_pkg::CMD_READ;
    wire  wr_cyc   = addr_cyc && dev_cmd[3:0] == sprq_pkg::CMD_WRITE;
    wire  resp_end = !agent_valid_n && agt_cmd[4] && agt_cmd[3:0] != sprq_pkg::MORE_DATA_TAG;

    sequence s_read_issued;
        rd_cyc ##1 !rd_cyc;
    endsequence
    sequence s_write_issued;
        wr_cyc ##1 !wr_cyc;
    endsequence

    // pending from the end of a read address cycle until the final response word
    always_ff @(posedge REF_CLK_IN) begin
        rd_prev_r <= RST_N_IN && rd_cyc;
        if (!RST_N_IN || resp_end) begin
            read_pending_r <= 1'b0;
        end else if (rd_prev_r && !rd_cyc) begin
            read_pending_r <= 1'b1;
        end
    end

    a_one_read: assert property (read_pending_r |-> !rd_cyc) else $error("second read issued");
    a_read_releases: assert property (s_read_issued |-> proc_owns_bus_n) else $error("bus kept");
    a_float_on_release: assert property (proc_owns_bus_n |-> dev_oe_n) else $error("not floated");
    a_agent_after_release: assert property (!agt_oe_n |-> proc_owns_bus_n && $past(proc_owns_bus_n))
        else $error("agent drove early");
    a_no_contention: assert property (dev_oe_n || agt_oe_n) else $error("both ends drive");
    a_accept_twice: assert property ($fell(agent_accept_n) |=> !agent_accept_n) else $error("short accept");
    a_addr_waits_accept: assert property (agent_accept_n [*3] ##0 addr_cyc |=> addr_cyc && $stable(dev_cmd))
        else $error("address cycle ended unaccepted");
    a_addr_hold_extra: assert property ($fell(agent_accept_n) && addr_cyc |=> addr_cyc)
        else $error("no extra address cycle");
    a_write_data_next: assert property (s_write_issued |-> ##[0:3] (!proc_valid_n && dev_cmd[4]))
        else $error("write without data");
    a_data_tags: assert property (!proc_valid_n && dev_cmd[4] |-> dev_cmd[3:0] == sprq_pkg::END_DATA_TAG
        || dev_cmd[3:0] == sprq_pkg::MORE_DATA_TAG) else $error("bad data tag");
    a_valid_while_drive: assert property (!agent_valid_n |-> !agt_oe_n) else $error("valid undriven");
    a_reclaim_two: assert property (resp_end && agent_bus_request_n |=> proc_owns_bus_n ##1 !proc_owns_bus_n)
        else $error("reclaim timing");
endmodule

// ---- verification/sysif_processor_request_protocol_test.sv ----
// self-checking bench: both link ends joined by one interface, user sides driven here
// assumes the package constants and the hand-over timing of the two ends
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %0t got %0h expected %0h", $time, got, exp); end end
module sysif_processor_request_protocol_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    logic [31:0] req_addr = '0;
    logic [3:0]  req_len = '0;
    logic        spaced = 1'b0;
    logic [31:0] wdata = '0;
    logic        wvalid = 1'b0;
    logic        accept_en = 1'b1;
    logic [31:0] resp_data = '0;
    logic        resp_err = 1'b0;
    logic        flt = 1'b0;
    int          errs = 0;
    wire         req_ready, wready, rvalid, rlast, bus_err;
    wire  [31:0] rdata;
    wire  [4:0]  seen_cmd;
    wire  [31:0] seen_ad;
    wire         seen_valid;
    int          failures = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          pk = 0;
    int          ek = 0;
    logic [36:0] dq[$], eq[$];
    int          tq[$], gq[$];

    sprq_link_if link ();
    // an undriven bus toggles each cycle so a stale value never passes for a live one
    assign link.cmd_id_bus    = !link.dev_oe_n ? link.dev_cmd : !link.agt_oe_n ? link.agt_cmd : {5{flt}};
    assign link.addr_data_bus = !link.dev_oe_n ? link.dev_ad : !link.agt_oe_n ? link.agt_ad : {32{flt}};

    sprq_dev #(.FIFO_DEPTH(8)) sprq_dev_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link.dev),
        .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready), .REQ_ADDR_IN(req_addr), .REQ_LEN_IN(req_len),
        .RATE_SPACED_IN(spaced), .WDATA_IN(wdata), .WDATA_VALID_IN(wvalid), .WDATA_READY_OUT(wready),
        .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvalid), .RDATA_LAST_OUT(rlast), .BUS_ERROR_OUT(bus_err));
    sprq_agent sprq_agent_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link.agt), .ACCEPT_EN_IN(accept_en),
        .RESP_DATA_IN(resp_data), .RESP_ERR_IN(resp_err), .SEEN_CMD_OUT(seen_cmd), .SEEN_AD_OUT(seen_ad),
        .SEEN_VALID_OUT(seen_valid));
    sprq_link_properties sprq_link_properties_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .dev_cmd(link.dev_cmd),
        .dev_oe_n(link.dev_oe_n), .agt_cmd(link.agt_cmd), .agt_oe_n(link.agt_oe_n),
        .proc_valid_n(link.proc_valid_n), .agent_valid_n(link.agent_valid_n),
        .agent_accept_n(link.agent_accept_n), .proc_owns_bus_n(link.proc_owns_bus_n),
        .agent_bus_request_n(link.agent_bus_request_n));

    always #5 clk = ~clk;

    // device data cycles with their cycle numbers; timeout ceiling
    always @(posedge clk) begin
        cyc++;
        flt <= ~flt;
        if (bus_err === 1'b1) errs <= errs + 1;
        if (rst_n && link.proc_valid_n === 1'b0 && link.dev_cmd[4] === 1'b1) begin
            dq.push_back({link.dev_cmd, link.dev_ad});
            tq.push_back(cyc);
        end
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // request stays up until taken; caller lowers it after the last of a run
    task automatic do_req(input logic [31:0] a, input logic [3:0] len);
        int n;
        req_addr = a;
        req_len = len;
        req_valid = 1'b1;
        for (n = 0; n < 500 && req_ready !== 1'b1; n++) tick();
        `CHK(req_ready, 1'b1)
        tick();
    endtask

    task automatic push(input int cnt);
        int n;
        repeat (cnt) begin
            wdata = 32'h5a00_0000 + 32'(pk);
            wvalid = 1'b1;
            for (n = 0; n < 100 && wready !== 1'b1; n++) tick();
            tick();
            pk++;
        end
        wvalid = 1'b0;
    endtask

    task automatic do_read(input logic [31:0] a, input logic [31:0] d, input logic e);
        int n;
        int e0;
        resp_data = d;
        resp_err = e;
        e0 = errs;
        do_req(a, sprq_pkg::LEN_RESET);
        req_valid = 1'b0;
        for (n = 0; n < 50 && link.proc_valid_n !== 1'b0; n++) tick();
        `CHK(link.cmd_id_bus, {1'b0, sprq_pkg::CMD_READ})
        `CHK(link.addr_data_bus, a)
        `CHK(req_ready, 1'b0)
        tick();
        `CHK(seen_cmd, {1'b0, sprq_pkg::CMD_READ})
        `CHK(seen_ad, a)
        `CHK(seen_valid, 1'b1)
        for (n = 0; n < 100 && rvalid !== 1'b1 && bus_err !== 1'b1; n++) tick();
        `CHK(rvalid, 1'b1)
        if (!e) `CHK(rdata, d)
        if (!e) `CHK(rlast, 1'b1)
        tick();
        tick();
        `CHK(errs - e0, int'(e))
        for (n = 0; n < 10 && link.proc_owns_bus_n !== 1'b0; n++) tick();
        `CHK(link.proc_owns_bus_n, 1'b0)
    endtask

    // issues four writes back to back; with accept withheld the first one must stall
    task automatic write_batch(input logic sp, input logic [3:0] lens [4]);
        int n;
        int k;
        int g;
        spaced = sp;
        g = sp ? 1 + sprq_pkg::SPACED_WAITS : 1;
        foreach (lens[i]) begin
            n = lens[i] <= 4 ? 1 : lens[i] < 8 ? 2 : lens[i] / 4;
            for (k = 0; k < n; k++) begin
                eq.push_back({1'b1, (lens[i] < 8 || k == n - 1) ? sprq_pkg::END_DATA_TAG : sprq_pkg::MORE_DATA_TAG,
                              32'h5a00_0000 + 32'(ek)});
                gq.push_back(k > 0 && lens[i] >= 8 ? g : 0);
                ek++;
            end
            do_req(32'h0000_1000 + 32'(i * 64), lens[i]);
            if (i == 0 && !accept_en) begin
                repeat (12) tick();
                `CHK(link.cmd_id_bus, {1'b0, sprq_pkg::CMD_WRITE})
                `CHK(link.proc_valid_n, 1'b0)
                accept_en = 1'b1;
            end
        end
        req_valid = 1'b0;
        for (n = 0; n < 2000 && dq.size() < eq.size(); n++) tick();
        `CHK(dq.size(), eq.size())
        foreach (eq[i]) begin
            `CHK(dq[i], eq[i])
            if (gq[i] != 0) `CHK(tq[i] - tq[i - 1], gq[i])
        end
        dq.delete();
        tq.delete();
        eq.delete();
        gq.delete();
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        `CHK(link.proc_owns_bus_n, 1'b0)
        `CHK(link.proc_valid_n, 1'b1)
        rst_n = 1'b1;
        tick();
        do_read(32'h0000_0040, 32'hcafe_0001, 1'b0);
        do_read(32'h0000_0080, 32'hdead_0002, 1'b1);
        // fifo fills while the agent withholds accept
        accept_en = 1'b0;
        push(8);
        `CHK(wready, 1'b0)
        write_batch(1'b0, '{4'h1, 4'h5, 4'h7, 4'hc});
        `CHK(wready, 1'b1)
        push(6);
        write_batch(1'b1, '{4'h8, 4'h8, 4'h4, 4'h1});
        report_and_stop();
    end
endmodule
